// File: rtl/lcd_cmd_pkg.sv
// Constants and types for the LCD driver bus command unit
package lcd_cmd_pkg;
   localparam logic [5:0] slave_addr_hi = 6'h1C;
   localparam logic [5:0] last_ram_addr = 6'h27;
   localparam logic [5:0] ptr_reset = 6'h00;
   localparam logic [2:0] subaddr_reset = 3'h0;
   localparam int unsigned ram_words = 40;
   localparam int unsigned blink_div1 = 768;
   localparam int unsigned blink_div2 = 1536;
   localparam int unsigned blink_div3 = 3072;
   localparam logic [1:0] mode_static = 2'h1;
   localparam logic [1:0] mode_bp2 = 2'h2;
   localparam logic [1:0] mode_bp3 = 2'h3;
   localparam logic [1:0] mode_bp4 = 2'h0;
   localparam logic [1:0] mode_reset = 2'h1;
   localparam int unsigned cont_bit = 7;
   localparam int unsigned enable_bit = 3;
   localparam int unsigned bias_bit = 2;
   typedef enum logic [2:0] {
      st_idle = 3'h0,
      st_addr = 3'h1,
      st_cmd = 3'h3,
      st_data = 3'h2,
      st_ignore = 3'h6
   } bus_state_t;
endpackage : lcd_cmd_pkg

// File: rtl/byte_buffer.sv
// Two-entry valid/ready buffer for received bytes
module byte_buffer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   input wire logic [8:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [8:0] out_data_o
);
   logic [8:0] mem_ff [2];
   logic wr_ptr_ff;
   logic rd_ptr_ff;
   logic [1:0] count_ff;
   wire push = in_valid_i && in_ready_o;
   wire pop = out_valid_o && out_ready_i;
   assign in_ready_o = count_ff != 2'h2;
   assign out_valid_o = count_ff != 2'h0;
   assign out_data_o = mem_ff[rd_ptr_ff];
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mem_ff[0] <= 9'h000;
         mem_ff[1] <= 9'h000;
         wr_ptr_ff <= 1'b0;
         rd_ptr_ff <= 1'b0;
         count_ff <= 2'h0;
      end else begin
         if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_i;
            wr_ptr_ff <= ~wr_ptr_ff;
         end
         if (pop) begin
            rd_ptr_ff <= ~rd_ptr_ff;
         end
         count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule : byte_buffer

// File: rtl/lcd_driver_bus_command_unit.sv
// Write-only two-wire slave and command decoder of a segment LCD driver
// Summary of operation
// - Display byte stored only when subaddress counter equals subaddress pins.
// - On mismatch no store, but data pointer still advances.
// - Pointer overflow past last address increments the subaddress counter.
// - Overflow may happen mid byte; later bits go to next device.
// - Blink rate is clock divided by 768, 1536 or 3072; off disables.
// - Alternate-bank blink toggles output bank in static or two-backplane mode.
// - Mode-set bit 3 blanks display when 0, shows when 1.
// - Mode-set is 10 in bits 6:5; bit 2 bias; bits 1:0 drive mode.
// - Slave address 0111 00x, x equal to address select pin.
// - Read accesses are never acknowledged.
// - Non-matching address ignores transfer until next start.
// - Matching device acknowledges address and every command byte that fits in the buffer.
// - Command bit 7 continues commands; zero makes later bytes display data.
// - Data bytes acknowledged only when subaddress pins match counter.
// - Bit 6 zero loads six low bits into data pointer.
// - Bits 6:3 equal 1100 load subaddress counter.
// - Bits 6:2 equal 11110 select input bank bit 1, output bank bit 0.
// - Bank value 0 selects RAM bit 0 or bits 0-1; 1 selects 2 or 2-3.
// - Bank-select ignored in three or four backplane modes.
// - Blink-select is 1110 in bits 6:3; bit 2 mode; bits 1:0 rate.
// - Pointer advances 8, 4, 3 or 2 per byte by drive mode.
module lcd_driver_bus_command_unit
   import lcd_cmd_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   input wire logic hw_subaddr_pin_bit0,
   input wire logic hw_subaddr_pin_bit1,
   input wire logic hw_subaddr_pin_bit2,
   input wire logic slave_addr_lsb_pin,
   output logic ram_we_o,
   output logic [5:0] ram_addr_o,
   output logic [3:0] ram_bit_mask_o,
   output logic [3:0] ram_wdata_o,
   input wire logic ram_ready_i,
   output logic display_enable_o,
   output logic bias_half_o,
   output logic [1:0] drive_mode_o,
   output logic [1:0] blink_rate_field,
   output logic blink_alt_o,
   output logic blink_phase_o,
   output logic input_bank_o,
   output logic output_bank_o,
   output logic [5:0] data_ptr_o,
   output logic [2:0] subaddr_cnt_o
);
   bus_state_t state_ff;
   bus_state_t nxt_state;
   logic scl_d_ff;
   logic sda_d_ff;
   logic [7:0] shift_ff;
   logic [3:0] bitcnt_ff;
   logic ack_ff;
   logic ack_pend_ff;
   logic enable_ff;
   logic bias_ff;
   logic [1:0] mode_ff;
   logic [1:0] brate_ff;
   logic balt_ff;
   logic ibank_ff;
   logic obank_ff;
   logic [5:0] ptr_ff;
   logic [2:0] sub_ff;
   logic [11:0] bdiv_ff;
   logic bphase_ff;
   logic [2:0] bit_idx_ff;
   logic [7:0] dbyte_ff;
   logic busy_ff;
   logic [8:0] buf_out;
   logic buf_valid;
   logic buf_in_ready;
   wire [2:0] hw_sub = {hw_subaddr_pin_bit2, hw_subaddr_pin_bit1, hw_subaddr_pin_bit0};
   wire scl_rise = scl_i && !scl_d_ff;
   wire scl_fall = !scl_i && scl_d_ff;
   wire start_cond = scl_i && scl_d_ff && sda_d_ff && !sda_i;
   wire stop_cond = scl_i && scl_d_ff && !sda_d_ff && sda_i;
   wire byte_done = scl_rise && bitcnt_ff == 4'h7;
   wire [7:0] rx_byte = {shift_ff[6:0], sda_i};
   wire addr_match = rx_byte[7:2] == slave_addr_hi && rx_byte[1] == slave_addr_lsb_pin
      && !rx_byte[0];
   wire sub_match = sub_ff == hw_sub;
   // Decode from buffer head: the shifter may already hold a later byte
   wire [7:0] cmd_byte = buf_out[7:0];
   wire is_mode = cmd_byte[6:5] == 2'h2;
   wire is_ptr = !cmd_byte[6];
   wire is_dev = cmd_byte[6:3] == 4'hC;
   wire is_bank = cmd_byte[6:2] == 5'h1E;
   wire is_blink = cmd_byte[6:3] == 4'hE;
   wire cmd_take = buf_valid && !buf_out[8] && !busy_ff;
   wire data_take = buf_valid && buf_out[8] && !busy_ff;
   wire bank_ok = mode_ff == mode_static || mode_ff == mode_bp2;
   logic [2:0] bits_per_word;
   always_comb begin
      case (mode_ff)
         mode_static: bits_per_word = 3'h1;
         mode_bp2: bits_per_word = 3'h2;
         mode_bp3: bits_per_word = 3'h3;
         default: bits_per_word = 3'h4;
      endcase
   end
   wire last_in_word = {1'b0, bit_idx_ff} + 4'h1 >= {1'b0, bits_per_word};
   wire [1:0] row_base = (bank_ok && ibank_ff) ? 2'h2 : 2'h0;
   wire [1:0] row = row_base + bit_idx_ff[1:0];
   logic [2:0] dbyte_cnt_ff;
   wire [2:0] bit_pos = 3'h7 - dbyte_cnt_ff;
   // Byte end closes a part-filled word, so 1:3 mode skips bit 2 of the third word
   wire word_end = last_in_word || dbyte_cnt_ff == 3'h7;
   logic [11:0] blink_limit;
   always_comb begin
      case (brate_ff)
         2'h1: blink_limit = 12'(blink_div1 / 2 - 1);
         2'h2: blink_limit = 12'(blink_div2 / 2 - 1);
         2'h3: blink_limit = 12'(blink_div3 / 2 - 1);
         default: blink_limit = 12'h000;
      endcase
   end

   wire last_bit_done = busy_ff && dbyte_cnt_ff == 3'h7 && ram_ready_i;
   // Buffer decouples bus from RAM writes; ack decided when byte completes
   byte_buffer u_buf (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .in_valid_i(byte_done && (state_ff == st_cmd || state_ff == st_data)),
      .in_data_i({state_ff == st_data, rx_byte}),
      .in_ready_o(buf_in_ready),
      .out_valid_o(buf_valid),
      .out_ready_i(cmd_take || (busy_ff && last_bit_done)),
      .out_data_o(buf_out)
   );

   // start resets decoder, ignore until start
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         st_idle: nxt_state = st_idle;
         st_addr: if (byte_done) nxt_state = addr_match ? st_cmd : st_ignore;
         st_cmd: if (byte_done && !rx_byte[cont_bit]) nxt_state = st_data;
         st_data: nxt_state = st_data;
         st_ignore: nxt_state = st_ignore;
         default: nxt_state = st_idle;
      endcase
      if (stop_cond) nxt_state = st_idle;
      if (start_cond) nxt_state = st_addr;
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_ff <= st_idle;
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
         shift_ff <= 8'h00;
         bitcnt_ff <= 4'h0;
      end else begin
         state_ff <= nxt_state;
         scl_d_ff <= scl_i;
         sda_d_ff <= sda_i;
         if (start_cond) begin
            bitcnt_ff <= 4'h0;
         end else if (scl_rise && bitcnt_ff < 4'h8) begin
            shift_ff <= rx_byte;
            bitcnt_ff <= bitcnt_ff + 4'h1;
         end else if (scl_fall && bitcnt_ff == 4'h9) begin
            bitcnt_ff <= 4'h0;
         end else if (scl_rise && bitcnt_ff == 4'h8) begin
            bitcnt_ff <= 4'h9;
         end
      end
   end

   // ack address and commands, data ack on subaddress match
   wire ack_now = byte_done && (
      (state_ff == st_addr && addr_match) ||
      (state_ff == st_cmd && buf_in_ready) ||
      (state_ff == st_data && buf_in_ready && sub_match));
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ack_pend_ff <= 1'b0;
         ack_ff <= 1'b0;
      end else begin
         if (start_cond || stop_cond) begin
            ack_pend_ff <= 1'b0;
            ack_ff <= 1'b0;
         end else if (byte_done) begin
            ack_pend_ff <= ack_now;
         end else if (scl_fall && bitcnt_ff == 4'h8) begin
            ack_ff <= ack_pend_ff;
         end else if (scl_fall && bitcnt_ff == 4'h9) begin
            ack_ff <= 1'b0;
         end
      end
   end
   // Open drain: enable is low while pulling the line low
   assign sda_o = 1'b0;
   assign sda_oe_o = !ack_ff;

   // Command execution
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         enable_ff <= 1'b0;
         bias_ff <= 1'b0;
         mode_ff <= mode_reset;
         brate_ff <= 2'h0;
         balt_ff <= 1'b0;
         ibank_ff <= 1'b0;
         obank_ff <= 1'b0;
      end else if (cmd_take) begin
         if (is_mode) begin
            enable_ff <= cmd_byte[enable_bit];
            bias_ff <= cmd_byte[bias_bit];
            mode_ff <= cmd_byte[1:0];
         end
         if (is_bank && bank_ok) begin
            ibank_ff <= cmd_byte[1];
            obank_ff <= cmd_byte[0];
         end
         if (is_blink) begin
            balt_ff <= cmd_byte[2];
            brate_ff <= cmd_byte[1:0];
         end
      end
   end

   // Data path: one bit per clock so overflow mid byte works
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ptr_ff <= ptr_reset;
         sub_ff <= subaddr_reset;
         busy_ff <= 1'b0;
         dbyte_cnt_ff <= 3'h0;
         bit_idx_ff <= 3'h0;
         dbyte_ff <= 8'h00;
      end else if (cmd_take) begin
         if (is_ptr) ptr_ff <= cmd_byte[5:0];
         if (is_dev) sub_ff <= cmd_byte[2:0];
         bit_idx_ff <= 3'h0;
      end else if (data_take) begin
         busy_ff <= 1'b1;
         dbyte_ff <= buf_out[7:0];
         dbyte_cnt_ff <= 3'h0;
      end else if (busy_ff && ram_ready_i) begin
         dbyte_cnt_ff <= dbyte_cnt_ff + 3'h1;
         if (dbyte_cnt_ff == 3'h7) busy_ff <= 1'b0;
         if (word_end) begin
            bit_idx_ff <= 3'h0;
            // overflow wraps pointer and bumps counter
            if (ptr_ff == last_ram_addr) begin
               ptr_ff <= ptr_reset;
               sub_ff <= sub_ff + 3'h1;
            end else begin
               ptr_ff <= ptr_ff + 6'h01;
            end
         end else begin
            bit_idx_ff <= bit_idx_ff + 3'h1;
         end
      end
   end
   // 1:3 mode leaves third-word bit 2 alone: byte ends after eight bits
   // write strobe gated by subaddress match
   assign ram_we_o = busy_ff && sub_match;
   assign ram_addr_o = ptr_ff;
   assign ram_bit_mask_o = 4'h1 << row;
   assign ram_wdata_o = {4{dbyte_ff[bit_pos]}};

   // blink divider, half period toggles phase
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         bdiv_ff <= 12'h000;
         bphase_ff <= 1'b0;
      end else if (brate_ff == 2'h0) begin
         bdiv_ff <= 12'h000;
         bphase_ff <= 1'b0;
      end else if (bdiv_ff >= blink_limit) begin
         bdiv_ff <= 12'h000;
         bphase_ff <= ~bphase_ff;
      end else begin
         bdiv_ff <= bdiv_ff + 12'h001;
      end
   end

   assign display_enable_o = enable_ff;
   assign bias_half_o = bias_ff;
   assign drive_mode_o = mode_ff;
   assign blink_rate_field = brate_ff;
   assign blink_alt_o = balt_ff;
   assign blink_phase_o = bphase_ff;
   assign input_bank_o = ibank_ff;
   assign output_bank_o = bank_ok && (obank_ff ^ (balt_ff && bphase_ff));
   assign data_ptr_o = ptr_ff;
   assign subaddr_cnt_o = sub_ff;
endmodule : lcd_driver_bus_command_unit

// File: dv/bus_master_model.sv
// Two-wire bus master model driving clock and open-drain data
module bus_master_model (
   input wire logic clk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   // Four clocks a phase keeps samples apart
   task automatic tick(input int k);
      repeat (k) @(posedge clk_i);
      #2;
   endtask : tick
   task automatic start_cond;
      sda_o = 1'b1;
      tick(4);
      scl_o = 1'b1;
      tick(4);
      sda_o = 1'b0;
      tick(4);
      scl_o = 1'b0;
      tick(4);
   endtask : start_cond
   task automatic stop_cond;
      sda_o = 1'b0;
      tick(4);
      scl_o = 1'b1;
      tick(4);
      sda_o = 1'b1;
      tick(4);
   endtask : stop_cond
   // data moves only while clock low
   task automatic send(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_o = b[i];
         tick(4);
         scl_o = 1'b1;
         tick(4);
         scl_o = 1'b0;
      end
      sda_o = 1'b1;
      tick(4);
      scl_o = 1'b1;
      tick(2);
      ack = !sda_i;
      tick(2);
      scl_o = 1'b0;
   endtask : send
endmodule : bus_master_model

// File: dv/lcd_cmd_assertions.sv
// Port checker for the bus command unit
module lcd_cmd_checker
   import lcd_cmd_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic scl_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic hw_subaddr_pin_bit0,
   input wire logic hw_subaddr_pin_bit1,
   input wire logic hw_subaddr_pin_bit2,
   input wire logic ram_we_o,
   input wire logic [1:0] drive_mode_o,
   input wire logic [1:0] blink_rate_field,
   input wire logic blink_alt_o,
   input wire logic blink_phase_o,
   input wire logic input_bank_o,
   input wire logic output_bank_o,
   input wire logic [5:0] data_ptr_o,
   input wire logic [2:0] subaddr_cnt_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [11:0] cnt_ff;
   logic seen_ff;
   logic [11:0] half_w;
   logic dual_w;
   assign half_w = (blink_rate_field == 2'h1) ? 12'(blink_div1 / 2) :
      (blink_rate_field == 2'h2) ? 12'(blink_div2 / 2) : 12'(blink_div3 / 2);
   assign dual_w = (drive_mode_o == mode_static) || (drive_mode_o == mode_bp2);
   // A rate change keeps the divider count running, so wait a full toggle
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_ff <= 12'h000;
         seen_ff <= 1'b0;
      end else begin
         cnt_ff <= $changed(blink_phase_o) ? 12'h001 : cnt_ff + 12'h001;
         seen_ff <= ($changed(blink_phase_o) || seen_ff) && !$changed(blink_rate_field);
      end
   end
   ack_drives_low_a: assert property (!sda_oe_o && scl_i |=> !scl_i || (!sda_oe_o && !sda_o))
      else $error("acknowledge not held low while clock high");
   ack_in_low_a: assert property ($fell(sda_oe_o) |-> !scl_i)
      else $error("acknowledge began with clock high");
   ack_release_a: assert property (!sda_oe_o && $fell(scl_i) |-> ##[1:4] sda_oe_o)
      else $error("acknowledge held past its clock");
   store_match_a: assert property (ram_we_o |->
      subaddr_cnt_o == {hw_subaddr_pin_bit2, hw_subaddr_pin_bit1, hw_subaddr_pin_bit0})
      else $error("store with subaddress mismatch");
   ptr_range_a: assert property (data_ptr_o <= last_ram_addr)
      else $error("data pointer past last address");
   wrap_carry_a: assert property ($past(data_ptr_o) == last_ram_addr &&
      data_ptr_o == ptr_reset |-> subaddr_cnt_o == $past(subaddr_cnt_o) + 3'h1)
      else $error("wrap without subaddress increment");
   bank_mode_a: assert property ($changed(input_bank_o) |-> dual_w)
      else $error("bank changed in three or four backplane mode");
   blink_off_a: assert property (blink_rate_field == 2'h0 && $past(blink_rate_field) == 2'h0
      && $past(blink_rate_field, 2) == 2'h0 |-> $stable(blink_phase_o))
      else $error("blink phase moved while off");
   blink_period_a: assert property ($changed(blink_phase_o) && seen_ff &&
      blink_rate_field != 2'h0 |-> cnt_ff == half_w)
      else $error("blink half period wrong");
   alt_bank_a: assert property ($changed(blink_phase_o) && blink_alt_o && $stable(blink_alt_o)
      && dual_w && $stable(drive_mode_o) |-> $changed(output_bank_o))
      else $error("output bank did not follow blink");
   ack_c: cover property ($fell(sda_oe_o));
   wrap_c: cover property ($past(data_ptr_o) == last_ram_addr && data_ptr_o == ptr_reset);
   blink_c: cover property ($changed(blink_phase_o) && seen_ff);
endmodule : lcd_cmd_checker
bind lcd_driver_bus_command_unit lcd_cmd_checker chk (.clk_i, .rst_i, .scl_i, .sda_o,
   .sda_oe_o, .hw_subaddr_pin_bit0, .hw_subaddr_pin_bit1, .hw_subaddr_pin_bit2, .ram_we_o,
   .drive_mode_o, .blink_rate_field, .blink_alt_o, .blink_phase_o, .input_bank_o,
   .output_bank_o, .data_ptr_o, .subaddr_cnt_o);

// File: dv/lcd_driver_bus_command_unit_test.sv
// Self-checking bench for the bus command unit
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
   $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module lcd_driver_bus_command_unit_test
   import lcd_cmd_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [2:0] hw_sub = 3'h0;
   logic addr_sel = 1'b0;
   logic m_scl, m_sda, sda_o, sda_oe_o, sda_line, we, en, bias, alt, phase, ib, ob;
   logic [1:0] mode, rate;
   logic [5:0] ptr;
   logic [2:0] sub;
   logic [5:0] waddr;
   logic [3:0] wmask, wdata;
   logic [3:0] ram [40] = '{default: 4'h0};
   int num_errors = 0;
   int tests_run = 0;
   int cyc = 0;
   int we_cnt = 0;
   int n;
   logic p;
   logic [1:0] md [4] = '{mode_bp3, mode_bp4, mode_static, mode_bp2};
   logic [5:0] adv [4] = '{6'h03, 6'h02, 6'h08, 6'h04};
   logic [11:0] half [4] = '{12'h000, 12'(blink_div1 / 2), 12'(blink_div2 / 2),
      12'(blink_div3 / 2)};
   // Pulled-up line is low if either party pulls
   assign sda_line = m_sda & (sda_oe_o ? 1'b1 : sda_o);
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   bus_master_model M (.clk_i(clk_i), .sda_i(sda_line), .scl_o(m_scl), .sda_o(m_sda));
   lcd_driver_bus_command_unit DUT (.clk_i(clk_i), .rst_i(rst_i), .scl_i(m_scl),
      .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .hw_subaddr_pin_bit0(hw_sub[0]),
      .hw_subaddr_pin_bit1(hw_sub[1]), .hw_subaddr_pin_bit2(hw_sub[2]),
      .slave_addr_lsb_pin(addr_sel), .ram_we_o(we), .ram_addr_o(waddr),
      .ram_bit_mask_o(wmask), .ram_wdata_o(wdata), .ram_ready_i(1'b1),
      .display_enable_o(en), .bias_half_o(bias),
      .drive_mode_o(mode), .blink_rate_field(rate), .blink_alt_o(alt),
      .blink_phase_o(phase), .input_bank_o(ib), .output_bank_o(ob), .data_ptr_o(ptr),
      .subaddr_cnt_o(sub));
   task automatic end_sim;
      if (num_errors == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_sim
   task automatic snd(input logic [7:0] b, input logic exp);
      logic a;
      M.send(b, a);
      `CHK("ack", exp, a)
   endtask : snd
   always @(posedge clk_i) begin
      cyc++;
      we_cnt <= we_cnt + int'(we === 1'b1);
      // Far-side display memory keeps only the masked rows
      if (we === 1'b1) ram[waddr] <= (ram[waddr] & ~wmask) | (wdata & wmask);
      if (cyc == 40000) begin
         num_errors++;
         end_sim();
      end
   end
   initial begin
      repeat (5) @(posedge clk_i);
      #2 rst_i = 1'b0;
      M.tick(3);
      `CHK("reset mode", mode_reset, mode)
      M.start_cond();
      snd(8'h72, 1'b0);
      snd(8'hCE, 1'b0);
      M.stop_cond();
      M.start_cond();
      snd(8'h71, 1'b0);
      M.stop_cond();
      `CHK("ignored mode", mode_reset, mode)
      addr_sel = 1'b1;
      M.start_cond();
      snd(8'h72, 1'b1);
      M.stop_cond();
      addr_sel = 1'b0;
      for (int i = 0; i < 4; i++) begin
         M.start_cond();
         snd(8'h70, 1'b1);
         snd(8'hCC | {6'h00, md[i]}, 1'b1);
         snd(8'hFB, 1'b1);
         snd(8'hE0, 1'b1);
         snd(8'h00, 1'b1);
         snd(8'hA5, 1'b1);
         M.stop_cond();
         `CHK("ptr step", adv[i], ptr)
         `CHK("mode", md[i], mode)
         `CHK("bias", 1'b1, bias)
         `CHK("enable", 1'b1, en)
         `CHK("in bank", i > 1, ib)
         `CHK("out bank", i > 1, ob)
      end
      M.start_cond();
      snd(8'h70, 1'b1);
      snd(8'hE0, 1'b1);
      snd(8'h26, 1'b1);
      we_cnt = 0;
      snd(8'hB7, 1'b1);
      snd(8'h0F, 1'b0);
      M.stop_cond();
      `CHK("stores", 4, we_cnt)
      `CHK("sub", 3'h1, sub)
      `CHK("ptr", 6'h06, ptr)
      `CHK("word 38", 4'h4, ram[38])
      `CHK("word 39", 4'hC, ram[39])
      // subaddress pins move only while the bus is idle
      hw_sub = 3'h1;
      M.start_cond();
      snd(8'h70, 1'b1);
      snd(8'h00, 1'b1);
      snd(8'h3C, 1'b1);
      M.stop_cond();
      `CHK("word 0", 2'h0, ram[0][3:2])
      `CHK("word 1", 2'h3, ram[1][3:2])
      `CHK("ptr next", 6'h04, ptr)
      for (int r = 0; r < 4; r++) begin
         M.start_cond();
         snd(8'h70, 1'b1);
         snd(8'hC2, 1'b1);
         snd(8'h74 | r[7:0], 1'b1);
         M.stop_cond();
         `CHK("rate", r[1:0], rate)
         `CHK("blank", 1'b0, en)
         `CHK("alt mode", 1'b1, alt)
         `CHK("third bias", 1'b0, bias)
         p = phase;
         n = 0;
         while (phase === p && n < 3200) begin
            M.tick(1);
            n++;
         end
         if (r == 0) begin
            `CHK("blink off", 3200, n)
         end else begin
            p = phase;
            n = 0;
            while (phase === p && n < 3200) begin
               M.tick(1);
               n++;
            end
            `CHK("blink half", half[r], 12'(n))
         end
         `CHK("alt bank", !phase, ob)
      end
      end_sim();
   end
endmodule : lcd_driver_bus_command_unit_test
